/* core/cra_serial_rx.sv */
/*
  cra_serial_rx: shift clock side of the serial write path.
  Assumes: frame framed by serial_select_n low with config_load_n high;
  sclk may stop between frames; the result is held until the next frame.
*/
`timescale 1ns/1ns
module cra_serial_rx (
  // shift clock domain
  input  wire logic                sclk,
  input  wire logic                presetn,
  // serial pins
  input  wire logic                serial_select_n,
  input  wire logic                config_load_n,
  input  wire logic                sdi,
  // decoded write
  output logic                     wr_toggle_q,
  output cra_pkg::cra_ser_wr_t     wr_q
);

  logic        frame_rst_n;
  logic [4:0]  bit_cnt_q;
  logic [22:0] shift_q;
  logic [23:0] frame_word;

  // outside a frame the shifter is held clear
  assign frame_rst_n = presetn & ~serial_select_n & config_load_n;
  assign frame_word  = {shift_q, sdi};

  // one bit per rising shift clock edge, msb first
  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 23'h000000;
    end
    else if (bit_cnt_q < cra_pkg::SER_FRAME_BITS)
    begin
      shift_q   <= frame_word[22:0];
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // instruction, spare bits, index, value
  always_ff @(posedge sclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_toggle_q <= 1'b0;
      wr_q        <= '0;
    end
    else if (frame_rst_n && bit_cnt_q == cra_pkg::SER_LAST_BIT)
    begin
      if (frame_word[23:cra_pkg::SER_INSTR_LSB] == cra_pkg::SER_WRITE_INSTR
          && frame_word[11:cra_pkg::SER_ADDR_LSB] >= cra_pkg::CFG_FIRST_IDX
          && frame_word[11:cra_pkg::SER_ADDR_LSB] <= cra_pkg::CFG_LAST_IDX)
      begin
        wr_q.reg_index <= frame_word[11:8];
        wr_q.reg_value <= frame_word[7:0];
        wr_toggle_q    <= ~wr_toggle_q;
      end
    end
  end

endmodule

/* core/cra_sync.sv */
/*
  cra_sync: two flip-flop synchroniser for a group of levels.
  Assumes: bits of a group are held stable by the sender across capture.
*/
`timescale 1ns/1ns
module cra_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* core/cra_top.sv */
/*
  cra_top: configuration register access port of a multi-queue fifo.
  Parallel path on the block clock, serial write path on the shift clock,
  apb view of the registers. Assumes pins come from another domain, that
  the fifo datapath consumes the push/pop strobes, and that the host
  keeps its own obligations.
*/
// Summary of operation
// - parallel write mode fills registers in order
// - write pointer wraps after tenth register
// - parallel read mode outputs registers in order
// - read pointer wraps after tenth register
// - load high, push low writes fifo memory
// - load high, pop low reads fifo memory
// - serial mode shifts one bit per rising edge
// - frame starts with write instruction 0x02
// - then 4 spare bits, 4-bit index and 8 data bits
// - serial select chooses serial or parallel path
// - no serial readback, parallel port and apb only
// - new value effective after eight cycles
`timescale 1ns/1ns
module cra_top (
  // clocks and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        sclk,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device pins
  input  wire logic        serial_select_n,
  input  wire logic        config_load_n,
  input  wire logic        push_en_n,
  input  wire logic        pop_en_n,
  input  wire logic [7:0]  din,
  input  wire logic        sdi,
  // parallel output port
  output logic      [7:0]  cfg_dout_q,
  output logic             cfg_dout_valid_q,
  // fifo datapath strobes
  output logic             fifo_push_q,
  output logic             fifo_pop_q,
  output logic      [7:0]  fifo_wdata_q,
  // settings in effect
  output logic      [2:0]  queue_mode_q,
  output logic             fast_clk_q
);

  localparam int unsigned PIN_W = $bits(cra_pkg::cra_pin_t);

  // pointer step with wrap back to the first register
  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    next_ptr = (p == cra_pkg::PTR_LAST) ? cra_pkg::PTR_RST : p + 4'h1;
  endfunction

  // apb byte address to register index, zero when none
  function automatic logic [3:0] cfg_index(input logic [7:0] a);
    cfg_index = 4'h0;
    if (a[1:0] == 2'h0 && a[7:2] >= 6'h01 && a[7:2] <= 6'h0A)
      cfg_index = a[5:2];
  endfunction

  cra_pkg::cra_pin_t    pin_raw;
  cra_pkg::cra_pin_t    pin_s;
  logic [PIN_W-1:0]     pin_vec;
  cra_pkg::cra_ser_wr_t ser_wr;
  logic                 ser_toggle;
  logic                 ser_toggle_s;
  logic                 ser_toggle_q;
  logic                 ser_wr_stb;
  cra_pkg::cra_mode_t   mode;

  logic [7:0] cfg_q    [cra_pkg::CFG_NUM];
  logic [7:0] active_q [cra_pkg::CFG_NUM];
  logic [3:0] wptr_q;
  logic [3:0] rptr_q;
  logic [3:0] settle_q;
  logic       illegal_q;
  logic       ser_seen_q;

  logic       apb_access;
  logic       apb_wr;
  logic       ptr_clr;
  logic       ill_clr;
  logic       par_wr;
  logic       par_rd;
  logic       any_wr;

  assign pin_raw.serial_select_n = serial_select_n;
  assign pin_raw.config_load_n   = config_load_n;
  assign pin_raw.push_en_n       = push_en_n;
  assign pin_raw.pop_en_n        = pop_en_n;
  assign pin_raw.din             = din;

  // pins into the block clock domain
  cra_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pin_raw),
    .q     (pin_vec)
  );

  assign pin_s = cra_pkg::cra_pin_t'(pin_vec);

  // serial path on the shift clock
  cra_serial_rx u_serial_rx (
    .sclk            (sclk),
    .presetn         (presetn),
    .serial_select_n (serial_select_n),
    .config_load_n   (config_load_n),
    .sdi             (sdi),
    .wr_toggle_q     (ser_toggle),
    .wr_q            (ser_wr)
  );

  // event crossing by toggle
  cra_sync #(
    .W (1)
  ) u_toggle_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ser_toggle),
    .q     (ser_toggle_s)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ser_toggle_q <= 1'b0;
    else
      ser_toggle_q <= ser_toggle_s;
  end

  assign ser_wr_stb = ser_toggle_s ^ ser_toggle_q;

  // pin decode
  always_comb
  begin
    mode = cra_pkg::CRA_IDLE;
    case ({pin_s.serial_select_n, pin_s.config_load_n,
           pin_s.push_en_n, pin_s.pop_en_n})
      4'b1001:
        mode = cra_pkg::CRA_CFG_WRITE;
      4'b1010:
        mode = cra_pkg::CRA_CFG_READ;
      4'b0001,
      4'b0011:
        mode = cra_pkg::CRA_ILLEGAL;
      default:
        mode = cra_pkg::CRA_IDLE;
    endcase
  end

  assign par_wr = (mode == cra_pkg::CRA_CFG_WRITE);
  assign par_rd = (mode == cra_pkg::CRA_CFG_READ);
  assign any_wr = ser_wr_stb | par_wr;

  // apb control decode
  assign apb_access = psel & penable;
  assign apb_wr     = apb_access & pwrite;
  assign ptr_clr    = apb_wr && paddr == cra_pkg::ADDR_CTRL
                      && pwdata[cra_pkg::CTRL_PTR_CLR];
  assign ill_clr    = apb_wr && paddr == cra_pkg::ADDR_CTRL
                      && pwdata[cra_pkg::CTRL_ILL_CLR];

  // configuration register store, serial write wins a collision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < cra_pkg::CFG_NUM; i++)
        cfg_q[i] <= cra_pkg::CFG_RST_VEC[i*8 +: 8];
    end
    else if (ser_wr_stb)
      cfg_q[ser_wr.reg_index - 4'h1] <= ser_wr.reg_value;
    else if (par_wr)
      cfg_q[wptr_q] <= pin_s.din;
  end

  // write pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wptr_q <= cra_pkg::PTR_RST;
    else if (ptr_clr)
      wptr_q <= cra_pkg::PTR_RST;
    else if (par_wr && !ser_wr_stb)
      wptr_q <= next_ptr(wptr_q);
  end

  // read pointer and parallel output port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rptr_q           <= cra_pkg::PTR_RST;
      cfg_dout_q       <= 8'h00;
      cfg_dout_valid_q <= 1'b0;
    end
    else
    begin
      cfg_dout_valid_q <= par_rd;
      if (ptr_clr)
        rptr_q <= cra_pkg::PTR_RST;
      else if (par_rd)
      begin
        cfg_dout_q <= cfg_q[rptr_q];
        rptr_q     <= next_ptr(rptr_q);
      end
    end
  end

  // fifo memory access when load is high, any serial select level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_push_q  <= 1'b0;
      fifo_pop_q   <= 1'b0;
      fifo_wdata_q <= 8'h00;
    end
    else
    begin
      fifo_push_q <= pin_s.config_load_n & ~pin_s.push_en_n;
      fifo_pop_q  <= pin_s.config_load_n & ~pin_s.pop_en_n;
      if (pin_s.config_load_n && !pin_s.push_en_n)
        fifo_wdata_q <= pin_s.din;
    end
  end

  // settle counter restarts on every write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_q <= 4'h0;
    else if (any_wr)
      settle_q <= cra_pkg::SETTLE_CYCLES;
    else if (settle_q != 4'h0)
      settle_q <= settle_q - 4'h1;
  end

  // copy into effect after the eighth cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < cra_pkg::CFG_NUM; i++)
        active_q[i] <= cra_pkg::CFG_RST_VEC[i*8 +: 8];
    end
    else if (settle_q == 4'h1 && !any_wr)
    begin
      for (int i = 0; i < cra_pkg::CFG_NUM; i++)
        active_q[i] <= cfg_q[i];
    end
  end

  assign queue_mode_q = active_q[cra_pkg::IDX_QUEUES - 4'h1][2:0];
  assign fast_clk_q   =
    active_q[cra_pkg::IDX_FAST_CLK - 4'h1][cra_pkg::FAST_CLK_BIT];

  // sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      illegal_q  <= 1'b0;
      ser_seen_q <= 1'b0;
    end
    else
    begin
      if (mode == cra_pkg::CRA_ILLEGAL)
        illegal_q <= 1'b1;
      else if (ill_clr)
        illegal_q <= 1'b0;
      if (ser_wr_stb)
        ser_seen_q <= 1'b1;
      else if (ill_clr)
        ser_seen_q <= 1'b0;
    end
  end

  // apb slave, zero wait states, config registers read only here
  assign pready = 1'b1;

  always_comb
  begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (cfg_index(paddr) != 4'h0)
    begin
      prdata[7:0] = cfg_q[cfg_index(paddr) - 4'h1];
      pslverr     = apb_access & pwrite;
    end
    else if (paddr == cra_pkg::ADDR_CTRL)
      prdata = 32'h0000_0000;
    else if (paddr == cra_pkg::ADDR_STATUS)
    begin
      prdata[3:0]                  = wptr_q;
      prdata[7:4]                  = rptr_q;
      prdata[cra_pkg::ST_ILLEGAL]  = illegal_q;
      prdata[cra_pkg::ST_SETTLING] = settle_q != 4'h0;
      prdata[cra_pkg::ST_SER_SEEN] = ser_seen_q;
    end
    else if (paddr == cra_pkg::ADDR_ACTIVE)
    begin
      prdata[2:0] = queue_mode_q;
      prdata[7]   = fast_clk_q;
    end
    else
      pslverr = apb_access;
  end

endmodule

/* dv/cra_chk_assertions.sv */
/*
  cra_chk: port assertions for cra_top.
  Assumes pins change just after rising pclk edges.
*/
`timescale 1ns/1ns
module cra_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  // pins
  input wire logic       serial_select_n,
  input wire logic       config_load_n,
  input wire logic       push_en_n,
  input wire logic       pop_en_n,
  input wire logic [7:0] din,
  // outputs
  input wire logic       cfg_dout_valid_q,
  input wire logic       fifo_push_q,
  input wire logic       fifo_pop_q,
  input wire logic [7:0] fifo_wdata_q
);
  wire logic push_m = config_load_n & ~push_en_n;
  wire logic pop_m  = config_load_n & ~pop_en_n;
  wire logic rd_m   = serial_select_n & ~config_load_n & ~pop_en_n
                      & push_en_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  push_on_a: assert property (push_m [*5] |-> fifo_push_q)
    else $error("fifo push missing");
  push_off_a: assert property (!push_m [*5] |-> !fifo_push_q)
    else $error("stray fifo push");
  push_data_a: assert property (
    fifo_push_q |-> fifo_wdata_q == $past(din, 3))
    else $error("fifo data wrong");
  pop_on_a: assert property (pop_m [*5] |-> fifo_pop_q)
    else $error("fifo pop missing");
  pop_off_a: assert property (!pop_m [*5] |-> !fifo_pop_q)
    else $error("stray fifo pop");
  rd_step_a: assert property (rd_m [*5] |-> cfg_dout_valid_q)
    else $error("read step missing");
  rd_cause_a: assert property (
    cfg_dout_valid_q |-> $past(rd_m, 3))
    else $error("read step without read mode");
  cfg_err_a: assert property (psel && penable && pwrite
    && paddr inside {[8'h04:8'h28]} |-> pslverr)
    else $error("config write not refused");
endmodule
bind cra_top cra_chk cra_chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pslverr, .serial_select_n, .config_load_n,
  .push_en_n, .pop_en_n, .din, .cfg_dout_valid_q, .fifo_push_q,
  .fifo_pop_q, .fifo_wdata_q);

/* dv/cra_host.sv */
/*
  cra_host: host side of the serial write port.
  Assumes the bench holds config_load_n high during a frame.
*/
`timescale 1ns/1ns
module cra_host (
  // serial port
  output logic sclk,
  output logic sdi,
  output logic sel_n
);
  initial
  begin
    sclk  = 1'b0;
    sdi   = 1'b1;
    sel_n = 1'b1;
  end
  // one frame, s high keeps select idle
  task automatic send(input logic [23:0] f, input logic s);
    sel_n = s;
    #30;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = f[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #30 sel_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

/* dv/cra_top_tb.sv */
/*
  cra_top_tb: directed test of the configuration register access port.
  Assumes cra_host drives the serial port, pins held by the bench.
*/
`timescale 1ns/1ns
module cra_top_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pm;
  logic [7:0]  din;
  logic [7:0]  cfg_dout_q;
  logic        cfg_dout_valid_q;
  logic [7:0]  fifo_wdata_q;
  logic        fifo_push_q;
  logic        fifo_pop_q;
  logic [2:0]  queue_mode_q;
  logic        fast_clk_q;
  logic        sclk;
  logic        sdi;
  logic        hsel;
  logic [31:0] rdata;
  logic        err;
  logic [7:0]  rq[$];
  int          failures;
  int          check_count;

  cra_host cra_host_i (.sclk, .sdi, .sel_n(hsel));
  cra_top cra_top_i (
    .pclk, .presetn, .sclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr,
    .serial_select_n(pm[3] & hsel), .config_load_n(pm[2]),
    .push_en_n(pm[1]), .pop_en_n(pm[0]), .din, .sdi,
    .cfg_dout_q, .cfg_dout_valid_q, .fifo_push_q, .fifo_pop_q,
    .fifo_wdata_q, .queue_mode_q, .fast_clk_q
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (cfg_dout_valid_q === 1'b1)
      rq.push_back(cfg_dout_q);

  task automatic finish_test;
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  // pins held n cycles, then idle
  task automatic run(input logic [3:0] m, input logic [7:0] d, int n);
    @(posedge pclk);
    pm  <= m;
    din <= d;
    repeat (n) @(posedge pclk);
    pm <= 4'hB;
  endtask

  task automatic ser(input logic [23:0] f, input logic s,
                     input logic [7:0] a, input logic [31:0] e);
    cra_host_i.send(f, s);
    repeat (8) @(posedge pclk);
    rdc(a, e);
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    failures++;
    finish_test();
  end

  initial
  begin
    presetn <= 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pm = 4'hB;
    din = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 1; j < 11; j++)
      rdc(8'(4 * j), 32'(cra_pkg::CFG_RST_VEC[8*j-8 +: 8]));
    rdc(cra_pkg::ADDR_ACTIVE, 32'h87);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge pclk);
      pm  <= 4'h9;
      din <= 8'hA0 + 8'(i);
    end
    @(posedge pclk);
    pm <= 4'hB;
    repeat (4) @(posedge pclk);
    chk(32'(queue_mode_q), 32'h7);
    repeat (15) @(posedge pclk);
    chk(32'(queue_mode_q), 32'h2);
    for (int j = 1; j < 11; j++)
      rdc(8'(4 * j), 32'((j == 1) ? 8'hAA : 8'hA0 + 8'(j - 1)));
    run(4'hA, 8'h00, 11);
    repeat (6) @(posedge pclk);
    chk(32'(rq.size()), 32'd11);
    for (int k = 0; k < 11; k++)
      chk(32'(rq[k]), 32'((k % 10 == 0) ? 8'hAA : 8'hA0 + 8'(k)));
    rdc(cra_pkg::ADDR_STATUS, 32'h11);
    run(4'h5, 8'h5A, 6);
    chk(32'(fifo_wdata_q), 32'h5A);
    chk(32'(fifo_push_q), 32'h1);
    run(4'hE, 8'h00, 6);
    chk(32'(fifo_pop_q), 32'h1);
    chk(32'(fifo_push_q), 32'h0);
    apb(1'b0, 8'h4C, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h08, 32'hFF);
    chk(32'(err), 32'h1);
    rdc(8'h08, 32'hA1);
    @(posedge pclk);
    pm <= 4'hF;
    ser({8'h02, 8'hF3, 8'h05}, 1'b0, 8'h0C, 32'h05);
    ser({8'h03, 8'h04, 8'h11}, 1'b0, 8'h10, 32'hA3);
    ser({8'h02, 8'h05, 8'h22}, 1'b1, 8'h14, 32'hA4);
    ser({8'h02, 8'h0A, 8'h00}, 1'b0, 8'h28, 32'h0);
    repeat (10) @(posedge pclk);
    chk(32'(fast_clk_q), 32'h0);
    chk(32'(queue_mode_q), 32'h5);
    run(4'h3, 8'h00, 5);
    apb(1'b0, cra_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rdata[8]), 32'h1);
    chk(rdata, 32'h0000_0511);
    apb(1'b1, cra_pkg::ADDR_CTRL, 32'h3);
    rdc(cra_pkg::ADDR_STATUS, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(cra_pkg::ADDR_ACTIVE, 32'h87);
    rdc(8'h0C, 32'h07);
    finish_test();
  end
endmodule

/* pkg/cra_pkg.sv */
/*
  cra_pkg: constants, field layouts and carrier types for the
  configuration register access port.
  Assumes: included first; used by the core files by scoped names only.
*/
package cra_pkg;

  // configuration register array
  localparam int unsigned CFG_NUM       = 10;
  localparam int unsigned CFG_W         = 8;
  localparam logic [3:0]  CFG_FIRST_IDX = 4'h1;
  localparam logic [3:0]  CFG_LAST_IDX  = 4'hA;
  localparam logic [3:0]  PTR_LAST      = 4'h9;
  localparam logic [3:0]  PTR_RST       = 4'h0;
  localparam logic [3:0]  IDX_QUEUES    = 4'h3;
  localparam logic [3:0]  IDX_FAST_CLK  = 4'hA;
  localparam int unsigned FAST_CLK_BIT  = 7;

  // values after reset, register 0x1 in the low byte
  localparam logic [79:0] CFG_RST_VEC =
    80'h80_00_00_7F_00_00_7F_07_00_00;

  // serial frame layout
  localparam logic [7:0]  SER_WRITE_INSTR = 8'h02;
  localparam logic [4:0]  SER_FRAME_BITS  = 5'h18;
  localparam logic [4:0]  SER_LAST_BIT    = 5'h17;
  localparam int unsigned SER_INSTR_LSB   = 16;
  localparam int unsigned SER_ADDR_LSB    = 8;

  // settle delay before a new value takes effect
  localparam logic [3:0]  SETTLE_CYCLES = 4'h8;

  // apb map, config register index i sits at byte 4*i
  localparam logic [7:0]  ADDR_CTRL   = 8'h40;
  localparam logic [7:0]  ADDR_STATUS = 8'h44;
  localparam logic [7:0]  ADDR_ACTIVE = 8'h48;
  localparam int unsigned CTRL_PTR_CLR = 0;
  localparam int unsigned CTRL_ILL_CLR = 1;
  localparam int unsigned ST_ILLEGAL   = 8;
  localparam int unsigned ST_SETTLING  = 9;
  localparam int unsigned ST_SER_SEEN  = 10;

  // synchronised pin group
  typedef struct packed {
    logic       serial_select_n;
    logic       config_load_n;
    logic       push_en_n;
    logic       pop_en_n;
    logic [7:0] din;
  } cra_pin_t;

  // one serial register write
  typedef struct packed {
    logic [3:0] reg_index;
    logic [7:0] reg_value;
  } cra_ser_wr_t;

  // pin decode modes
  typedef enum logic [2:0] {
    CRA_IDLE,
    CRA_CFG_WRITE,
    CRA_CFG_READ,
    CRA_ILLEGAL
  } cra_mode_t;

endpackage
